/* File: design/bfa_pkg.sv */
// Shared constants of the byte file ALU: register map, fields, opcodes, reset values.
package bfa_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] BFA_CMD_OFS = 8'h00;
   localparam logic [7:0] BFA_ACC_OFS = 8'h04;
   localparam logic [7:0] BFA_STAT_OFS = 8'h08;
   localparam logic [7:0] BFA_PTR_OFS = 8'h0C;
   localparam logic [7:0] BFA_FDATA_OFS = 8'h10;
   localparam logic [7:0] BFA_FADDR_OFS = 8'h14;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BFA_CMD_OP_LSB = 0;
   localparam int BFA_CMD_DEST_BIT = 4;
   localparam int BFA_CMD_FILE_LSB = 5;
   localparam int BFA_STAT_CARRY_BIT = 0;
   localparam int BFA_STAT_NIB_BIT = 1;
   localparam int BFA_STAT_ZERO_BIT = 2;
   localparam int BFA_STAT_SKIP_BIT = 3;
   localparam int BFA_STAT_BUSY_BIT = 4;

   // ------------------------------------------------------------
   // Operation codes
   // ------------------------------------------------------------
   localparam logic [3:0] BFA_OP_SUB = 4'h0;
   localparam logic [3:0] BFA_OP_INC = 4'h1;
   localparam logic [3:0] BFA_OP_INC_SKIP = 4'h2;
   localparam logic [3:0] BFA_OP_DEC = 4'h3;
   localparam logic [3:0] BFA_OP_DEC_SKIP = 4'h4;
   localparam logic [3:0] BFA_OP_ACC_NULL = 4'h5;
   localparam logic [3:0] BFA_OP_REG_NULL = 4'h6;
   localparam logic [3:0] BFA_OP_AND = 4'h7;
   localparam logic [3:0] BFA_OP_OR = 4'h8;
   localparam logic [3:0] BFA_OP_XOR = 4'h9;
   localparam logic [3:0] BFA_OP_INV = 4'hA;

   // ------------------------------------------------------------
   // Reset values and bus answers
   // ------------------------------------------------------------
   localparam logic [7:0] BFA_ACC_RST = 8'h00;
   localparam logic [4:0] BFA_PTR_RST = 5'h00;
   localparam logic [4:0] BFA_INDIRECT_ADDR = 5'h00;
   localparam logic [1:0] BFA_RESP_OKAY = 2'h0;
   localparam logic [1:0] BFA_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      BFA_IDLE,
      BFA_FETCH,
      BFA_EXEC,
      BFA_SKIP_CYC
   } bfa_state_type;

endpackage

/* File: design/bfa_file_mem.sv */
// Register file storage: one write port, one read port with registered read data.
`timescale 1ns/1ps

module bfa_file_mem #(
   parameter int DATA_W = 8,
   parameter int DEPTH = 32,
   parameter int ADDR_W = 5
) (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic wr_en_in,
   input wire logic [ADDR_W-1:0] wr_addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic rd_en_in,
   input wire logic [ADDR_W-1:0] rd_addr_in,
   output logic [DATA_W-1:0] rd_data_out
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (DEPTH > (1 << ADDR_W) || DEPTH < 2) begin : g_bad_depth
      $error("bfa_file_mem: depth does not fit the address width");
   end

   logic [DATA_W-1:0] mem_q [DEPTH];

   // Storage has no reset; software must load registers before use
   always_ff @(posedge mclk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end

   // Read data registered so the memory can map onto a RAM macro
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_out <= '0;
      end else if (rd_en_in) begin
         rd_data_out <= mem_q[rd_addr_in];
      end
   end

endmodule

/* File: design/bfa_alu.sv */
// Combinational byte ALU: result, flag values and flag write enables per operation.
`timescale 1ns/1ps

module bfa_alu
   import bfa_pkg::*;
(
   input wire logic [3:0] op_in,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] fval_in,
   output logic [7:0] result_out,
   output logic carry_out,
   output logic nibble_out,
   output logic zero_out,
   output logic carry_we_out,
   output logic nibble_we_out,
   output logic zero_we_out,
   output logic skip_out,
   output logic known_out
);

   logic [8:0] diff9;
   logic [4:0] diff5;

   // Subtract as f + ~w + 1; carry out high means no borrow
   assign diff9 = {1'b0, fval_in} + {1'b0, ~acc_in} + 9'h001;
   assign diff5 = {1'b0, fval_in[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;

   // Operation select; flags only move where the enable says so
   always_comb begin
      result_out = fval_in;
      carry_we_out = 1'b0;
      nibble_we_out = 1'b0;
      zero_we_out = 1'b1;
      skip_out = 1'b0;
      known_out = 1'b1;
      case (op_in)
         BFA_OP_SUB: begin
            result_out = diff9[7:0]; // Raw two's complement kept
            carry_we_out = 1'b1;
            nibble_we_out = 1'b1;
         end
         BFA_OP_INC: result_out = fval_in + 8'h01;
         BFA_OP_INC_SKIP: begin
            result_out = fval_in + 8'h01;
            zero_we_out = 1'b0;
            skip_out = (fval_in == 8'hFF);
         end
         BFA_OP_DEC: result_out = fval_in - 8'h01;
         BFA_OP_DEC_SKIP: begin
            result_out = fval_in - 8'h01;
            zero_we_out = 1'b0; // Flags untouched
            skip_out = (fval_in == 8'h01);
         end
         BFA_OP_ACC_NULL: result_out = 8'h00;
         BFA_OP_REG_NULL: result_out = 8'h00;
         BFA_OP_AND: result_out = acc_in & fval_in;
         BFA_OP_OR: result_out = acc_in | fval_in;
         BFA_OP_XOR: result_out = acc_in ^ fval_in; // Zero when equal
         BFA_OP_INV: result_out = ~fval_in;
         default: begin
            zero_we_out = 1'b0;
            known_out = 1'b0;
         end
      endcase
   end

   assign carry_out = diff9[8]; // Set when acc not above file
   assign nibble_out = diff5[4]; // Cleared when low acc nibble larger
   assign zero_out = (result_out == 8'h00); // After subtract: operands equal

endmodule

/* File: design/bfa_top.sv */
// Byte file ALU with AXI4-Lite register access, file storage and skip sequencing.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps

module bfa_top
   import bfa_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int FILE_DEPTH = 32
) (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic busy_out,
   output logic skip_pending_out
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W < 5 || FILE_DEPTH != 32) begin : g_bad_param
      $error("bfa_top: address width too small or file depth not 32");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   bfa_state_type state_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic aw_full_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_full_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic [ADDR_W-1:0] araddr_q;
   logic rd_wait_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [9:0] cmd_q;
   logic [7:0] acc_q;
   logic carry_q;
   logic nibble_overflow_bit_q;
   logic zero_q;
   logic skip_q;
   logic [4:0] pointer_select_reg_q;
   logic [4:0] faddr_q;
   logic wr_go;
   logic rd_go;
   logic wr_hit;
   logic rd_hit;
   logic cmd_wr;
   logic [4:0] eff_addr;
   logic [7:0] fval;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_z;
   logic alu_c_we;
   logic alu_dc_we;
   logic alu_z_we;
   logic alu_skip;
   logic alu_known;
   logic [3:0] op;
   logic dest_reg;
   logic exec_acc_we;
   logic exec_reg_we;
   logic mem_we;
   logic [4:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic mem_re;
   logic [4:0] mem_raddr;
   logic is_skip_op;

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   // Writes complete only while the engine rests, so no flag can be
   // written by software and hardware in the same cycle
   assign wr_go = aw_full_q && w_full_q && !bvalid_q && (state_q == BFA_IDLE);
   assign s_axi_awready_out = !aw_full_q;
   assign s_axi_wready_out = !w_full_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;

   always_comb begin
      wr_hit = 1'b1;
      if (awaddr_q == BFA_CMD_OFS) begin
         wr_hit = 1'b1;
      end else if (awaddr_q == BFA_ACC_OFS || awaddr_q == BFA_STAT_OFS) begin
         wr_hit = 1'b1;
      end else if (awaddr_q == BFA_PTR_OFS || awaddr_q == BFA_FDATA_OFS) begin
         wr_hit = 1'b1;
      end else if (awaddr_q == BFA_FADDR_OFS) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   assign cmd_wr = wr_go && (awaddr_q == BFA_CMD_OFS) && wstrb_q[1] && wstrb_q[0];

   // Address and data are held separately; either may come first
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aw_full_q <= 1'b0;
         awaddr_q <= '0;
         w_full_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (s_axi_awvalid_in && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
         end else if (wr_go) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid_in && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
         end else if (wr_go) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // Write response, error for unmapped addresses
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bvalid_q <= 1'b0;
         bresp_q <= BFA_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? BFA_RESP_OKAY : BFA_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         bvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   // One wait cycle on every read covers the registered file memory
   assign rd_go = s_axi_arvalid_in && !rd_wait_q && !rvalid_q && (state_q == BFA_IDLE);
   assign s_axi_arready_out = !rd_wait_q && !rvalid_q && (state_q == BFA_IDLE);
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         araddr_q <= '0;
         rd_wait_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= BFA_RESP_OKAY;
      end else begin
         if (rd_go) begin
            araddr_q <= s_axi_araddr_in;
         end
         rd_wait_q <= rd_go;
         if (rd_wait_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? BFA_RESP_OKAY : BFA_RESP_SLVERR;
            rdata_q <= '0;
            if (araddr_q == BFA_CMD_OFS) begin
               rdata_q[9:0] <= cmd_q;
            end else if (araddr_q == BFA_ACC_OFS) begin
               rdata_q[7:0] <= acc_q;
            end else if (araddr_q == BFA_STAT_OFS) begin
               rdata_q[BFA_STAT_CARRY_BIT] <= carry_q;
               rdata_q[BFA_STAT_NIB_BIT] <= nibble_overflow_bit_q;
               rdata_q[BFA_STAT_ZERO_BIT] <= zero_q;
               rdata_q[BFA_STAT_SKIP_BIT] <= skip_q;
               rdata_q[BFA_STAT_BUSY_BIT] <= (state_q != BFA_IDLE);
            end else if (araddr_q == BFA_PTR_OFS) begin
               rdata_q[4:0] <= pointer_select_reg_q;
            end else if (araddr_q == BFA_FDATA_OFS) begin
               rdata_q[7:0] <= fval;
            end else if (araddr_q == BFA_FADDR_OFS) begin
               rdata_q[4:0] <= faddr_q;
            end
         end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign rd_hit = (araddr_q == BFA_CMD_OFS) || (araddr_q == BFA_ACC_OFS) ||
                   (araddr_q == BFA_STAT_OFS) || (araddr_q == BFA_PTR_OFS) ||
                   (araddr_q == BFA_FDATA_OFS) || (araddr_q == BFA_FADDR_OFS);

   // ------------------------------------------------------------
   // Command decode and operand fetch
   // ------------------------------------------------------------
   assign op = cmd_q[BFA_CMD_OP_LSB +: 4];
   assign dest_reg = cmd_q[BFA_CMD_DEST_BIT];
   // Address zero goes through the pointer
   assign eff_addr = (cmd_q[BFA_CMD_FILE_LSB +: 5] == BFA_INDIRECT_ADDR) ?
                     pointer_select_reg_q : cmd_q[BFA_CMD_FILE_LSB +: 5];
   assign is_skip_op = (op == BFA_OP_INC_SKIP) || (op == BFA_OP_DEC_SKIP);

   // Destination choice; the two clear operations have a fixed target
   always_comb begin
      exec_acc_we = 1'b0;
      exec_reg_we = 1'b0;
      if (state_q == BFA_EXEC && alu_known) begin
         if (op == BFA_OP_ACC_NULL) begin
            exec_acc_we = 1'b1;
         end else if (op == BFA_OP_REG_NULL) begin
            exec_reg_we = 1'b1; // Destination forced to file
         end else begin
            exec_reg_we = dest_reg;
            exec_acc_we = !dest_reg;
         end
      end
   end

   // Memory ports shared by engine and bus; bus uses them only at rest
   assign mem_re = (state_q == BFA_FETCH) || rd_go;
   assign mem_raddr = (state_q == BFA_FETCH) ? eff_addr : faddr_q;
   assign mem_we = exec_reg_we ||
                   (wr_go && awaddr_q == BFA_FDATA_OFS && wstrb_q[0]);
   assign mem_waddr = exec_reg_we ? eff_addr : faddr_q;
   assign mem_wdata = exec_reg_we ? alu_res : wdata_q[7:0];

   bfa_file_mem #(
      .DATA_W(8),
      .DEPTH(FILE_DEPTH),
      .ADDR_W(5)
   ) u_mem (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .wr_en_in(mem_we),
      .wr_addr_in(mem_waddr),
      .wr_data_in(mem_wdata),
      .rd_en_in(mem_re),
      .rd_addr_in(mem_raddr),
      .rd_data_out(fval)
   );

   bfa_alu u_alu (
      .op_in(op),
      .acc_in(acc_q),
      .fval_in(fval),
      .result_out(alu_res),
      .carry_out(alu_c),
      .nibble_out(alu_dc),
      .zero_out(alu_z),
      .carry_we_out(alu_c_we),
      .nibble_we_out(alu_dc_we),
      .zero_we_out(alu_z_we),
      .skip_out(alu_skip),
      .known_out(alu_known)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // A command taken while a skip is pending is swallowed as a no-op
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= BFA_IDLE;
         cmd_q <= '0;
      end else begin
         case (state_q)
            BFA_IDLE: begin
               if (cmd_wr && !skip_q) begin
                  cmd_q <= wdata_q[9:0];
                  state_q <= BFA_FETCH;
               end
            end
            BFA_FETCH: state_q <= BFA_EXEC;
            BFA_EXEC: state_q <= is_skip_op ? BFA_SKIP_CYC : BFA_IDLE;
            BFA_SKIP_CYC: state_q <= BFA_IDLE;
            default: state_q <= BFA_IDLE;
         endcase
      end
   end

   // Skip request: set by a skipping increment or decrement reaching zero, used up by next command
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         skip_q <= 1'b0;
      end else if (state_q == BFA_EXEC && alu_skip) begin
         skip_q <= 1'b1;
      end else if (cmd_wr && skip_q) begin
         skip_q <= 1'b0; // Taken from the bus, not fetched or executed
      end
   end

   // ------------------------------------------------------------
   // Accumulator, flags, pointer and file address registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_q <= BFA_ACC_RST;
      end else if (exec_acc_we) begin
         acc_q <= alu_res;
      end else if (wr_go && awaddr_q == BFA_ACC_OFS && wstrb_q[0]) begin
         acc_q <= wdata_q[7:0];
      end
   end

   // Flags move as the ALU enables them during execution, or by a status write at rest
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         carry_q <= 1'b0;
         nibble_overflow_bit_q <= 1'b0;
         zero_q <= 1'b0;
      end else if (state_q == BFA_EXEC) begin
         if (alu_c_we) begin
            carry_q <= alu_c;
         end
         if (alu_dc_we) begin
            nibble_overflow_bit_q <= alu_dc;
         end
         if (alu_z_we) begin
            zero_q <= alu_z;
         end
      end else if (wr_go && awaddr_q == BFA_STAT_OFS && wstrb_q[0]) begin
         carry_q <= wdata_q[BFA_STAT_CARRY_BIT];
         nibble_overflow_bit_q <= wdata_q[BFA_STAT_NIB_BIT];
         zero_q <= wdata_q[BFA_STAT_ZERO_BIT];
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pointer_select_reg_q <= BFA_PTR_RST;
         faddr_q <= '0;
      end else if (wr_go && wstrb_q[0]) begin
         if (awaddr_q == BFA_PTR_OFS) begin
            pointer_select_reg_q <= wdata_q[4:0];
         end else if (awaddr_q == BFA_FADDR_OFS) begin
            faddr_q <= wdata_q[4:0];
         end
      end
   end

   assign busy_out = (state_q != BFA_IDLE);
   assign skip_pending_out = skip_q;

endmodule

/* File: test/bfa_top_chk.sv */
// Port-level assertions of the byte file ALU.
`timescale 1ns/1ps
module bfa_top_chk
   import bfa_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic busy_out,
   input wire logic skip_pending_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   // ------------------------------------------------------------
   // Bus answers and engine timing
   // ------------------------------------------------------------
   rd_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##2 s_axi_rvalid_out)
      else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
   b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
   bad_read_a: assert property (s_axi_rvalid_out && s_axi_rresp_out == BFA_RESP_SLVERR |->
      s_axi_rdata_out == 32'h0000_0000) else $error("unmapped read not zero");
   busy_len_a: assert property ($rose(busy_out) |=> busy_out ##[1:2] !busy_out)
      else $error("engine cycle count wrong");
   skip_len_a: assert property ($rose(skip_pending_out) |-> busy_out ##1 !busy_out)
      else $error("skip cycle missing");
   skip_clr_a: assert property ($fell(skip_pending_out) |-> ##[0:1] s_axi_bvalid_out)
      else $error("skip cleared without command");
   busy_stall_a: assert property (busy_out |-> !s_axi_arready_out)
      else $error("read taken while busy");
endmodule
bind bfa_top bfa_top_chk u_chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
   .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
   .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
   .s_axi_bready_in(s_axi_bready_in), .busy_out(busy_out), .skip_pending_out(skip_pending_out));

/* File: test/bfa_seq_model.sv */
// Sequencer-side bus master that issues register accesses.
`timescale 1ns/1ps
module bfa_seq_model (
   input wire logic mclk_in,
   output logic [7:0] awaddr_out,
   output logic awvalid_out,
   input wire logic awready_in,
   output logic [31:0] wdata_out,
   output logic wvalid_out,
   input wire logic wready_in,
   input wire logic [1:0] bresp_in,
   input wire logic bvalid_in,
   output logic bready_out,
   output logic [7:0] araddr_out,
   output logic arvalid_out,
   input wire logic arready_in,
   input wire logic [31:0] rdata_in,
   input wire logic [1:0] rresp_in,
   input wire logic rvalid_in,
   output logic rready_out
);
   // Idle bus; released payloads flip so stale values never pass
   initial begin
      {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
      {araddr_out, arvalid_out, rready_out} = '0;
   end
   // Answer readiness starts at random but is raised a cycle later, before any answer can arrive, so no answer is ever held
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      @(posedge mclk_in);
      awaddr_out <= a;
      wdata_out <= d;
      awvalid_out <= 1'b1;
      wvalid_out <= 1'b1;
      bready_out <= 1'($urandom);
      do begin
         @(posedge mclk_in);
         if (awvalid_out && awready_in) begin
            awvalid_out <= 1'b0;
            awaddr_out <= ~a;
         end
         if (wvalid_out && wready_in) begin
            wvalid_out <= 1'b0;
            wdata_out <= ~d;
         end
         done = bvalid_in && bready_out;
         if (!done) begin
            bready_out <= 1'b1;
         end
      end while (!done);
      r = bresp_in;
      bready_out <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      @(posedge mclk_in);
      araddr_out <= a;
      arvalid_out <= 1'b1;
      rready_out <= 1'($urandom);
      do begin
         @(posedge mclk_in);
         if (arvalid_out && arready_in) begin
            arvalid_out <= 1'b0;
            araddr_out <= ~a;
         end
         done = rvalid_in && rready_out;
         if (!done) begin
            rready_out <= 1'b1;
         end
      end while (!done);
      d = rdata_in;
      r = rresp_in;
      rready_out <= 1'b0;
   endtask
endmodule

/* File: test/byte_file_alu_ops_bench.sv */
// Randomised self-checking bench of the byte file ALU against a reference model.
`timescale 1ns/1ps
module byte_file_alu_ops_bench
   import bfa_pkg::*;
;
   logic mclk_in, rstn_in, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, busy, skp;
   logic [7:0] aw, ar;
   logic [31:0] wd, rd_d, rdv;
   logic [1:0] bresp, rresp, rs;
   int miscompares, check_count, seed_v;
   bfa_top u_bfa_top (.mclk_in(mclk_in), .rstn_in(rstn_in), .s_axi_awaddr_in(aw),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rd_d), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rr), .busy_out(busy), .skip_pending_out(skp));
   bfa_seq_model u_bfa_seq_model (.mclk_in(mclk_in), .awaddr_out(aw), .awvalid_out(awv),
      .awready_in(awr), .wdata_out(wd), .wvalid_out(wv), .wready_in(wr_rdy), .bresp_in(bresp),
      .bvalid_in(bv), .bready_out(br), .araddr_out(ar), .arvalid_out(arv), .arready_in(arr),
      .rdata_in(rd_d), .rresp_in(rresp), .rvalid_in(rv), .rready_out(rr));
   // ------------------------------------------------------------
   // Clock, verdict and compare helpers
   // ------------------------------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   task automatic wrap_up();
      if (miscompares == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      u_bfa_seq_model.wr(a, d, rs);
   endtask
   task automatic r(input logic [7:0] a);
      u_bfa_seq_model.rd(a, rdv, rs);
   endtask
   // Reference model: one operation on random operands, then results read back
   task automatic run_op(input logic [3:0] op);
      logic [7:0] a, f, res, ea;
      logic [4:0] fa, p;
      logic [3:0] fl;
      logic d, to_acc;
      logic [7:0] pick [4];
      pick = '{8'h00, 8'h01, 8'hFF, 8'($urandom)};
      f = pick[$urandom_range(3)];
      a = ($urandom_range(2) == 0) ? f : 8'($urandom);
      fl = {1'b0, 3'($urandom)};
      d = 1'($urandom);
      fa = ($urandom_range(3) == 0) ? 5'h00 : 5'($urandom);
      p = 5'($urandom_range(31, 1));
      ea = {3'h0, (fa == BFA_INDIRECT_ADDR) ? p : fa};
      w(BFA_PTR_OFS, {27'h0, p});
      w(BFA_FADDR_OFS, {24'h0, ea});
      w(BFA_FDATA_OFS, {24'h0, f});
      w(BFA_ACC_OFS, {24'h0, a});
      w(BFA_STAT_OFS, {28'h0, fl});
      w(BFA_CMD_OFS, {22'h0, fa, d, op});
      case (op)
         BFA_OP_SUB: res = f + ~a + 8'h01;
         BFA_OP_INC, BFA_OP_INC_SKIP: res = f + 8'h01;
         BFA_OP_DEC, BFA_OP_DEC_SKIP: res = f - 8'h01;
         BFA_OP_AND: res = a & f;
         BFA_OP_OR: res = a | f;
         BFA_OP_XOR: res = a ^ f;
         BFA_OP_INV: res = ~f;
         default: res = 8'h00;
      endcase
      if (op == BFA_OP_SUB) fl[2:0] = {res == 8'h00, !(a[3:0] > f[3:0]), a <= f};
      else if (op <= BFA_OP_INV && op != BFA_OP_INC_SKIP && op != BFA_OP_DEC_SKIP)
         fl[2] = (res == 8'h00);
      if (op == BFA_OP_INC_SKIP || op == BFA_OP_DEC_SKIP) fl[3] = (res == 8'h00);
      to_acc = (op == BFA_OP_ACC_NULL) || (op != BFA_OP_REG_NULL && !d);
      if (op > BFA_OP_INV) res = to_acc ? a : f;
      w(BFA_FADDR_OFS, {24'h0, ea});
      r(BFA_FDATA_OFS);
      chk("file", rdv, {24'h0, to_acc ? f : res});
      r(BFA_ACC_OFS);
      chk("acc", rdv, {24'h0, to_acc ? res : a});
      r(BFA_STAT_OFS);
      chk("flags", {28'h0, rdv[3:0]}, {28'h0, fl});
      if (fl[3]) begin
         w(BFA_CMD_OFS, {22'h0, 5'h01, 1'b0, BFA_OP_INV});
         r(BFA_STAT_OFS);
         chk("skipped", {28'h0, rdv[3:0]}, {29'h0, fl[2:0]});
      end
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      rstn_in = 1'b0;
      repeat (16) @(posedge mclk_in);
      rstn_in <= 1'b1;
      seed_v = $urandom(92736);
      r(BFA_ACC_OFS);
      chk("acc reset", rdv, {24'h0, BFA_ACC_RST});
      r(BFA_STAT_OFS);
      chk("status reset", rdv, 32'h0000_0000);
      r(BFA_PTR_OFS);
      chk("pointer reset", rdv, {27'h0, BFA_PTR_RST});
      w(8'h18, 32'h0000_00FF);
      chk("unmapped wr", {30'h0, rs}, {30'h0, BFA_RESP_SLVERR});
      r(8'h18);
      chk("unmapped rd", {rdv[29:0], rs}, {30'h0, BFA_RESP_SLVERR});
      for (int i = 0; i < 144; i++) run_op(4'(i % 12));
      wrap_up();
   end
   // Generous bound; a normal run needs roughly a tenth of it
   initial begin
      #(25 * 60000);
      miscompares++;
      wrap_up();
   end
endmodule
